// ### mfr_regs.svh
// Constants for the fan motor mode controller: register offsets, fields, resets.
// Assumes inclusion by bare name from the design modules and the bench.
`ifndef MFR_REGS_SVH
`define MFR_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define MFR_OFF_CMD 4'h0
`define MFR_OFF_STATUS 4'h1
`define MFR_OFF_FLT_EN 4'h2
`define MFR_OFF_IRQ_STAT 4'h3
`define MFR_OFF_IRQ_MASK 4'h4
`define MFR_OFF_GAINS 4'h5
`define MFR_OFF_REGEN_LMT 4'h6
`define MFR_OFF_PUMP_LMT 4'h7
`define MFR_OFF_MODE 4'h8

// ----------------------------------------------------------------
// Command bits
// ----------------------------------------------------------------
`define MFR_CMD_STOP 0
`define MFR_CMD_START 1
`define MFR_CMD_BRAKE 2
`define MFR_CMD_LOWSIDE 3

// ----------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------
`define MFR_ST_OV 0
`define MFR_ST_UV 1
`define MFR_ST_OT 2
`define MFR_ST_OC 3
`define MFR_ST_EE 4
`define MFR_ST_STALL 5
`define MFR_ST_SYNC 6
`define MFR_ST_SPD 7
`define MFR_ST_PWR 8
`define MFR_ST_GEN 9
`define MFR_ST_REGEN 10

// ----------------------------------------------------------------
// Interrupt event bits
// ----------------------------------------------------------------
`define MFR_IRQ_FAIL 0
`define MFR_IRQ_STBY 1
`define MFR_IRQ_GEN 2

// ----------------------------------------------------------------
// Gain fields and reset values
// ----------------------------------------------------------------
`define MFR_GAIN_CUR_LSB 0
`define MFR_GAIN_OBS_LSB 4
`define MFR_GAIN_SPD_LSB 8
`define MFR_RST_FLT_EN 6'h3F
`define MFR_RST_GAINS 12'h000
`define MFR_RST_REGEN 16'h0000
`define MFR_RST_PUMP 16'hFFFF
`define MFR_RST_MASK 3'h0
`define MFR_STARTUP_CYC 8'h0A

`endif

// ### mfr_pkg.sv
// Types shared by the fan motor mode controller.
// Assumes mfr_regs.svh holds the numeric constants.
package mfr_pkg;

    // ----------------------------------------------------------------
    // Modes and states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {MFR_MODE_STBY, MFR_MODE_ROT, MFR_MODE_BRAKE, MFR_MODE_FAIL} mfr_mode_e;
    typedef enum logic [2:0] {MFR_ST_IDLE, MFR_ST_WAIT, MFR_ST_ALIGN, MFR_ST_RAMP, MFR_ST_DRIVE,
        MFR_ST_BRK, MFR_ST_FAILED} mfr_state_e;

    // ----------------------------------------------------------------
    // Fault and measurement bundles
    // ----------------------------------------------------------------
    typedef struct packed {
        logic ov;
        logic uv;
        logic ot;
        logic oc;
        logic ee;
        logic stall;
    } mfr_fault_s;

    typedef struct packed {
        logic synced;
        logic spd_lmt;
        logic pwr_lmt;
        logic decel;
        logic signed [15:0] i_ref;
        logic [15:0] vbb;
    } mfr_meas_s;

endpackage : mfr_pkg

// ### mfr_regen_limit.sv
// Regenerative current clamp and supply pump-up limiter.
// Assumes same-clock inputs; a negative reference means braking current.
`timescale 1ns/1ps
`include "mfr_regs.svh"
module mfr_regen_limit #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Controls
    input wire logic i_decel,
    input wire logic i_lowside,
    input wire logic signed [W-1:0] i_ref,
    input wire logic [W-1:0] i_vbb,
    input wire logic [W-1:0] i_regen_lmt,
    input wire logic [W-1:0] i_pump_lmt,
    // Results
    output logic signed [W-1:0] o_ref,
    output logic o_gen_lmt,
    output logic o_regen_lmt
);

    // ----------------------------------------------------------------
    // Limit decode
    // ----------------------------------------------------------------
    wire logic neg = i_ref[W-1];
    wire logic signed [W:0] neg_mag = -{i_ref[W-1], i_ref};
    wire logic signed [W:0] neg_lim = $signed({1'b0, i_regen_lmt});
    wire logic over_cur = i_decel && neg && (neg_mag > neg_lim);
    wire logic gen_mode = i_decel && neg && !i_lowside;
    wire logic over_v = gen_mode && (i_vbb >= i_pump_lmt);
    wire logic signed [W-1:0] clamp_ref = -$signed(i_regen_lmt);
    wire logic signed [W-1:0] next_ref = over_v ? '0 : (over_cur ? clamp_ref : i_ref);

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_ref <= '0;
            o_gen_lmt <= 1'b0;
            o_regen_lmt <= 1'b0;
        end else begin
            o_ref <= next_ref;
            o_gen_lmt <= over_v;
            o_regen_lmt <= over_cur;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    regen_clamp_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        over_cur && !over_v |=> o_ref == $past(clamp_ref)) else $error("regen clamp not applied");
    zero_coast_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_decel && i_regen_lmt == '0 |=> !o_ref[W-1]) else $error("regen current with zero limit");
    pump_stop_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        over_v |=> o_ref == '0 && o_gen_lmt) else $error("pump-up limit not applied");
    lowside_off_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_lowside |=> !o_gen_lmt) else $error("pump-up limit during low-side brake");
    pump_hit_c: cover property (@(posedge i_mclk) disable iff (i_rst) over_v);

endmodule : mfr_regen_limit

// ### mfr_ctrl.sv
// Top of the fan motor mode controller: mode machine, faults, registers, limiter.
// Assumes one 10 MHz clock, same-clock register port, asynchronous fault pins.
//
// Behaviour
// - Four top modes and seven internal states form the mode machine.
// - Startup completion or stop command enters standby and its state.
// - Start command leaves standby and enters rotate mode.
// - Brake command switches the controller into brake mode.
// - Only enabled faults move the machine into fail mode.
// - Active-low fault pin is asserted throughout fail mode.
// - PI gain settings are powers of two; plus one doubles gain.
// - Regenerative current during deceleration is clamped to the regen limit.
// - Braking current is regulated so supply stays below pump-up limit.
// - Pump-up limit acts only in generator mode, not low-side brake.
// - Zero regen limit means no regen current; motor coasts down.
`timescale 1ns/1ps
`include "mfr_regs.svh"
module mfr_ctrl #(
    parameter int W = 16,
    parameter int GW = 4
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Fault pins
    input wire logic [5:0] i_fault_pins,
    // Measurements
    input wire mfr_pkg::mfr_meas_s i_meas,
    // Motor outputs
    output logic o_fault_output_n,
    output logic [1:0] o_mode,
    output logic [2:0] o_state,
    output logic signed [W-1:0] o_cur_ref,
    output logic [W+15:0] o_kp_cur,
    output logic [W+15:0] o_kp_obs,
    output logic [W+15:0] o_kp_spd,
    output logic o_irq
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Two flops keep a metastable pin level away from the fault logic.
    logic [5:0] flt_s1;
    logic [5:0] flt_s2;
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            flt_s1 <= '0;
            flt_s2 <= '0;
        end else begin
            flt_s1 <= i_fault_pins;
            flt_s2 <= flt_s1;
        end
    end
    mfr_pkg::mfr_fault_s flt;
    assign flt = flt_s2;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [5:0] flt_en;
    logic [3*GW-1:0] gains;
    logic [W-1:0] regen_lmt;
    logic [W-1:0] pump_lmt;
    // The low-side select is a stored level, rewritten by every command write.
    logic lowside;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [7:0] boot_cnt;
    mfr_pkg::mfr_mode_e mode;
    mfr_pkg::mfr_state_e state;
    logic gen_hit;
    logic regen_hit;

    wire logic wr_cmd = i_wr && i_addr == `MFR_OFF_CMD;
    wire logic wr_flt = i_wr && i_addr == `MFR_OFF_FLT_EN;
    wire logic wr_ist = i_wr && i_addr == `MFR_OFF_IRQ_STAT;
    wire logic wr_msk = i_wr && i_addr == `MFR_OFF_IRQ_MASK;
    wire logic wr_gain = i_wr && i_addr == `MFR_OFF_GAINS;
    wire logic wr_regen = i_wr && i_addr == `MFR_OFF_REGEN_LMT;
    wire logic wr_pump = i_wr && i_addr == `MFR_OFF_PUMP_LMT;
    wire logic cmd_stop = wr_cmd && i_wdata[`MFR_CMD_STOP];
    wire logic cmd_start = wr_cmd && i_wdata[`MFR_CMD_START];
    wire logic cmd_brake = wr_cmd && i_wdata[`MFR_CMD_BRAKE];
    wire logic fault_hit = |(flt & flt_en);
    wire logic boot_done = boot_cnt == `MFR_STARTUP_CYC;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            flt_en <= `MFR_RST_FLT_EN;
            gains <= `MFR_RST_GAINS;
            regen_lmt <= `MFR_RST_REGEN;
            pump_lmt <= `MFR_RST_PUMP;
            lowside <= 1'b0;
            irq_mask <= `MFR_RST_MASK;
        end else begin
            if (wr_flt) flt_en <= i_wdata[5:0];
            if (wr_gain) gains <= i_wdata[3*GW-1:0];
            if (wr_regen) regen_lmt <= i_wdata[W-1:0];
            if (wr_pump) pump_lmt <= i_wdata[W-1:0];
            if (wr_cmd) lowside <= i_wdata[`MFR_CMD_LOWSIDE];
            if (wr_msk) irq_mask <= i_wdata[2:0];
        end
    end

    // ----------------------------------------------------------------
    // Mode machine
    // ----------------------------------------------------------------
    mfr_pkg::mfr_state_e next_state;
    mfr_pkg::mfr_mode_e next_mode;
    always_comb begin
        next_state = state;
        case (state)
            mfr_pkg::MFR_ST_IDLE: begin
                if (boot_done) next_state = mfr_pkg::MFR_ST_WAIT;
            end
            mfr_pkg::MFR_ST_WAIT: begin
                if (cmd_start) next_state = mfr_pkg::MFR_ST_ALIGN;
            end
            mfr_pkg::MFR_ST_ALIGN: begin
                next_state = mfr_pkg::MFR_ST_RAMP;
            end
            mfr_pkg::MFR_ST_RAMP: begin
                if (i_meas.synced) next_state = mfr_pkg::MFR_ST_DRIVE;
            end
            mfr_pkg::MFR_ST_DRIVE: begin
                next_state = mfr_pkg::MFR_ST_DRIVE;
            end
            mfr_pkg::MFR_ST_BRK: begin
                next_state = mfr_pkg::MFR_ST_BRK;
            end
            mfr_pkg::MFR_ST_FAILED: begin
                if (!fault_hit && cmd_stop) next_state = mfr_pkg::MFR_ST_WAIT;
            end
            default: begin
                next_state = mfr_pkg::MFR_ST_IDLE;
            end
        endcase
        // Stop beats brake in every running state, and an enabled fault beats both.
        if (state != mfr_pkg::MFR_ST_IDLE && state != mfr_pkg::MFR_ST_FAILED) begin
            if (cmd_stop) next_state = mfr_pkg::MFR_ST_WAIT;
            else if (cmd_brake) next_state = mfr_pkg::MFR_ST_BRK;
        end
        if (fault_hit) next_state = mfr_pkg::MFR_ST_FAILED;
        case (next_state)
            mfr_pkg::MFR_ST_IDLE: next_mode = mfr_pkg::MFR_MODE_STBY;
            mfr_pkg::MFR_ST_WAIT: next_mode = mfr_pkg::MFR_MODE_STBY;
            mfr_pkg::MFR_ST_BRK: next_mode = mfr_pkg::MFR_MODE_BRAKE;
            mfr_pkg::MFR_ST_FAILED: next_mode = mfr_pkg::MFR_MODE_FAIL;
            default: next_mode = mfr_pkg::MFR_MODE_ROT;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state <= mfr_pkg::MFR_ST_IDLE;
            mode <= mfr_pkg::MFR_MODE_STBY;
            boot_cnt <= '0;
            o_fault_output_n <= 1'b1;
        end else begin
            state <= next_state;
            mode <= next_mode;
            if (!boot_done) boot_cnt <= boot_cnt + 8'h01;
            o_fault_output_n <= next_mode != mfr_pkg::MFR_MODE_FAIL;
        end
    end

    // ----------------------------------------------------------------
    // Binary-scaled gains
    // ----------------------------------------------------------------
    // Each exponent is a shift amount, so one step up doubles the gain.
    logic [W+15:0] next_kp [3];
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gain_g
            assign next_kp[g] = (W+16)'(1) << gains[g*GW +: GW];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Regenerative limiter
    // ----------------------------------------------------------------
    wire logic decel_act = i_meas.decel && mode == mfr_pkg::MFR_MODE_ROT;
    wire logic brake_low = lowside && mode == mfr_pkg::MFR_MODE_BRAKE;
    logic signed [W-1:0] lim_ref;
    mfr_regen_limit #(.W(W)) u_regen (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_decel(decel_act || (mode == mfr_pkg::MFR_MODE_BRAKE && !lowside)),
        .i_lowside(brake_low),
        .i_ref(i_meas.i_ref),
        .i_vbb(i_meas.vbb),
        .i_regen_lmt(regen_lmt),
        .i_pump_lmt(pump_lmt),
        .o_ref(lim_ref),
        .o_gen_lmt(gen_hit),
        .o_regen_lmt(regen_hit)
    );

    // ----------------------------------------------------------------
    // Interrupts and read data
    // ----------------------------------------------------------------
    // Mode entries are taken from the next mode, so each flag lines up with its mode change.
    wire logic ev_fail = next_mode == mfr_pkg::MFR_MODE_FAIL && mode != mfr_pkg::MFR_MODE_FAIL;
    wire logic ev_stby = next_mode == mfr_pkg::MFR_MODE_STBY && mode != mfr_pkg::MFR_MODE_STBY;
    wire logic [2:0] ev = {gen_hit, ev_stby, ev_fail};
    // A clear and a new event in one cycle leave the bit set, so no event is lost.
    wire logic [2:0] clr = wr_ist ? i_wdata[2:0] : 3'h0;
    wire logic [2:0] next_irq_stat = ev | (irq_stat & ~clr);
    wire logic [10:0] stat_word = {regen_hit, gen_hit, i_meas.pwr_lmt, i_meas.spd_lmt, i_meas.synced,
        flt.stall, flt.ee, flt.oc, flt.ot, flt.uv, flt.ov};
    logic [31:0] next_rdata;
    always_comb begin
        case (i_addr)
            `MFR_OFF_STATUS: next_rdata = {21'h0, stat_word};
            `MFR_OFF_FLT_EN: next_rdata = {26'h0, flt_en};
            `MFR_OFF_IRQ_STAT: next_rdata = {29'h0, irq_stat};
            `MFR_OFF_IRQ_MASK: next_rdata = {29'h0, irq_mask};
            `MFR_OFF_GAINS: next_rdata = {{(32-3*GW){1'b0}}, gains};
            `MFR_OFF_REGEN_LMT: next_rdata = {{(32-W){1'b0}}, regen_lmt};
            `MFR_OFF_PUMP_LMT: next_rdata = {{(32-W){1'b0}}, pump_lmt};
            `MFR_OFF_MODE: next_rdata = {27'h0, state, mode};
            default: next_rdata = 32'h0;
        endcase
        // Zero outside a read cycle, so the read bus can be OR-combined.
        if (!i_rd) next_rdata = 32'h0;
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            irq_stat <= '0;
            o_irq <= 1'b0;
            o_rdata <= '0;
            o_mode <= '0;
            o_state <= '0;
            o_cur_ref <= '0;
            o_kp_cur <= '0;
            o_kp_obs <= '0;
            o_kp_spd <= '0;
        end else begin
            irq_stat <= next_irq_stat;
            o_irq <= |(next_irq_stat & irq_mask);
            o_rdata <= next_rdata;
            o_mode <= next_mode;
            o_state <= next_state;
            o_cur_ref <= lim_ref;
            o_kp_cur <= next_kp[0];
            o_kp_obs <= next_kp[1];
            o_kp_spd <= next_kp[2];
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    fail_pin_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_fault_output_n == (mode != mfr_pkg::MFR_MODE_FAIL)) else $error("fault pin disagrees with mode");
    fault_enter_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        fault_hit |=> mode == mfr_pkg::MFR_MODE_FAIL) else $error("enabled fault missed");
    masked_fault_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        mode != mfr_pkg::MFR_MODE_FAIL && !fault_hit |=> mode != mfr_pkg::MFR_MODE_FAIL)
        else $error("disabled fault caused fail");
    start_rot_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        state == mfr_pkg::MFR_ST_WAIT && cmd_start && !cmd_brake && !fault_hit && !cmd_stop
        |=> mode == mfr_pkg::MFR_MODE_ROT)
        else $error("start did not rotate");
    stop_stby_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        mode == mfr_pkg::MFR_MODE_ROT && cmd_stop && !fault_hit |=> state == mfr_pkg::MFR_ST_WAIT)
        else $error("stop did not enter standby");
    boot_stby_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        state == mfr_pkg::MFR_ST_IDLE && boot_done && !fault_hit |=> state == mfr_pkg::MFR_ST_WAIT)
        else $error("startup did not reach standby");
    brake_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        mode == mfr_pkg::MFR_MODE_ROT && cmd_brake && !cmd_stop && !fault_hit |=> mode == mfr_pkg::MFR_MODE_BRAKE)
        else $error("brake not entered");
    gain_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        wr_gain && i_wdata[GW-1:0] != '1 ##1 !wr_gain |=> o_kp_cur == (W+16)'(1) << $past(gains[GW-1:0], 1))
        else $error("gain not power of two");
    fail_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        mode == mfr_pkg::MFR_MODE_FAIL && !cmd_stop |=> !o_fault_output_n)
        else $error("fault pin released during fail");
    stop_fail_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        mode == mfr_pkg::MFR_MODE_FAIL && cmd_stop && !fault_hit |=> state == mfr_pkg::MFR_ST_WAIT)
        else $error("stop did not leave fail");
    boot_wait_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        state == mfr_pkg::MFR_ST_IDLE && !boot_done && !fault_hit |=> state == mfr_pkg::MFR_ST_IDLE)
        else $error("standby entered before startup completed");
    irq_set_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        ev != 3'h0 |=> (irq_stat & $past(ev)) == $past(ev))
        else $error("interrupt event lost");
    rdata_idle_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        !i_rd |=> o_rdata == 32'h0)
        else $error("read data outside read cycle");
    fail_c: cover property (@(posedge i_mclk) disable iff (i_rst) mode == mfr_pkg::MFR_MODE_FAIL);
    stby_c: cover property (@(posedge i_mclk) disable iff (i_rst) ev_stby);
    rot_c: cover property (@(posedge i_mclk) disable iff (i_rst) state == mfr_pkg::MFR_ST_DRIVE);
    brake_c: cover property (@(posedge i_mclk) disable iff (i_rst) mode == mfr_pkg::MFR_MODE_BRAKE);

endmodule : mfr_ctrl

// ### mfr_motor_model.sv
// Model of the motor and bridge side: fault pin levels and measurement bundle.
// Assumes the bench sets the physical conditions on the mfr_ctrl clock.
`timescale 1ns/1ps
module mfr_motor_model (
    // Conditions from the bench
    input wire logic [5:0] i_flt,
    input wire logic i_sync,
    input wire logic i_spd,
    input wire logic i_pwr,
    input wire logic i_decel,
    input wire logic signed [15:0] i_ref,
    input wire logic [15:0] i_vbb,
    // Towards the controller
    output logic [5:0] o_fault_pins,
    output mfr_pkg::mfr_meas_s o_meas
);
    // --------------------------------------------------------------
    // Pins and measurements
    // --------------------------------------------------------------
    // Fault levels reach the pins a little after the edge, as from an asynchronous source.
    assign #3 o_fault_pins = i_flt;
    assign o_meas = '{synced: i_sync, spd_lmt: i_spd, pwr_lmt: i_pwr, decel: i_decel, i_ref: i_ref, vbb: i_vbb};
endmodule : mfr_motor_model

// ### motor_mode_fsm_regen_limit_tb.sv
// Self-checking bench for mfr_ctrl with the motor model on its far side.
// Assumes mfr_regs.svh and mfr_pkg are compiled first.
`timescale 1ns/1ps
`include "mfr_regs.svh"
module motor_mode_fsm_regen_limit_tb;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic [5:0] fault_pins;
    mfr_pkg::mfr_meas_s meas;
    logic o_fault_output_n;
    logic [1:0] o_mode;
    logic [2:0] o_state;
    logic signed [15:0] o_cur_ref;
    logic [31:0] o_kp_cur, o_kp_obs, o_kp_spd;
    logic o_irq;
    logic [5:0] flt = 6'h00;
    logic sync = 1'b0, spd = 1'b0, pwr = 1'b0, decel = 1'b0;
    logic signed [15:0] ref_in = 16'h0000;
    logic [15:0] vbb = 16'h0000;
    logic [31:0] rv;
    int n_fail = 0;
    int checked = 0;

    mfr_motor_model model_u (.i_flt(flt), .i_sync(sync), .i_spd(spd), .i_pwr(pwr), .i_decel(decel),
        .i_ref(ref_in), .i_vbb(vbb), .o_fault_pins(fault_pins), .o_meas(meas));
    mfr_ctrl #(.W(16), .GW(4)) dut_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_fault_pins(fault_pins), .i_meas(meas),
        .o_fault_output_n(o_fault_output_n), .o_mode(o_mode), .o_state(o_state), .o_cur_ref(o_cur_ref),
        .o_kp_cur(o_kp_cur), .o_kp_obs(o_kp_obs), .o_kp_spd(o_kp_spd), .o_irq(o_irq));

    // --------------------------------------------------------------
    // Clock, helpers
    // --------------------------------------------------------------
    initial begin
        forever #50 i_mclk = ~i_mclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : wr

    // Read data stand in the cycle after the strobe edge only.
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask : cyc

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_reset();
        int k;
        chk({o_fault_output_n, o_mode, o_state}, {1'b1, 2'h0, 3'h0});
        for (k = 0; k < 30 && o_state !== 3'h1; k++) cyc(1);
        chk(o_state, 3'h1);
        chk(o_mode, 2'h0);
        rd(`MFR_OFF_FLT_EN, rv); chk(rv, 32'h0000003F);
        rd(`MFR_OFF_PUMP_LMT, rv); chk(rv, 32'h0000FFFF);
        rd(`MFR_OFF_REGEN_LMT, rv); chk(rv, 32'h00000000);
        rd(`MFR_OFF_IRQ_MASK, rv); chk(rv, 32'h00000000);
        rd(4'hF, rv); chk(rv, 32'h00000000);
        wr(`MFR_OFF_IRQ_STAT, 32'h00000007);
    endtask : t_reset

    task automatic t_start();
        wr(`MFR_OFF_CMD, 32'h00000002);
        #1 chk({o_mode, o_state}, {2'h1, 3'h2});
        cyc(1); chk(o_state, 3'h3);
        sync <= 1'b1;
        cyc(3); chk(o_state, 3'h4);
    endtask : t_start

    task automatic t_gains();
        wr(`MFR_OFF_GAINS, 32'h00000321);
        cyc(2);
        chk(o_kp_cur, 32'h00000002);
        chk(o_kp_obs, 32'h00000004);
        chk(o_kp_spd, 32'h00000008);
        wr(`MFR_OFF_GAINS, 32'h00000432);
        cyc(2);
        chk(o_kp_cur, 32'h00000004);
        chk(o_kp_spd, 32'h00000010);
    endtask : t_gains

    task automatic t_regen();
        wr(`MFR_OFF_REGEN_LMT, 32'h00000064);
        decel <= 1'b1;
        ref_in <= -16'sd500;
        cyc(4);
        chk($unsigned(o_cur_ref), 32'h0000FF9C);
        rd(`MFR_OFF_STATUS, rv); chk(rv[10], 1'b1);
        wr(`MFR_OFF_REGEN_LMT, 32'h00000000);
        cyc(4); chk(o_cur_ref, 16'h0000);
        wr(`MFR_OFF_REGEN_LMT, 32'h00000064);
        wr(`MFR_OFF_PUMP_LMT, 32'h00001000);
        vbb <= 16'h2000;
        cyc(4); chk(o_cur_ref, 16'h0000);
        rd(`MFR_OFF_STATUS, rv); chk(rv[9], 1'b1);
        rd(`MFR_OFF_IRQ_STAT, rv); chk(rv[2], 1'b1);
        chk(o_irq, 1'b0);
    endtask : t_regen

    task automatic t_brake();
        wr(`MFR_OFF_CMD, 32'h00000004);
        cyc(1); chk({o_mode, o_state}, {2'h2, 3'h5});
        wr(`MFR_OFF_CMD, 32'h0000000C);
        cyc(4);
        chk($unsigned(o_cur_ref), 32'h0000FE0C);
        wr(`MFR_OFF_CMD, 32'h00000001);
        cyc(1); chk({o_mode, o_state}, {2'h0, 3'h1});
        rd(`MFR_OFF_IRQ_STAT, rv); chk(rv[1], 1'b1);
        decel <= 1'b0;
        vbb <= 16'h0000;
    endtask : t_brake

    task automatic t_fault();
        wr(`MFR_OFF_IRQ_STAT, 32'h00000007);
        wr(`MFR_OFF_IRQ_MASK, 32'h00000001);
        wr(`MFR_OFF_FLT_EN, 32'h0000003B);
        flt <= 6'h04;
        cyc(6); chk({o_fault_output_n, o_mode}, {1'b1, 2'h0});
        flt <= 6'h05;
        cyc(5); chk({o_fault_output_n, o_mode, o_state}, {1'b0, 2'h3, 3'h6});
        chk(o_irq, 1'b1);
        wr(`MFR_OFF_CMD, 32'h00000002);
        cyc(3); chk({o_fault_output_n, o_mode}, {1'b0, 2'h3});
        flt <= 6'h00;
        cyc(4); chk(o_fault_output_n, 1'b0);
        wr(`MFR_OFF_CMD, 32'h00000001);
        cyc(1); chk({o_fault_output_n, o_mode}, {1'b1, 2'h0});
        wr(`MFR_OFF_IRQ_STAT, 32'h00000007);
        cyc(2); chk(o_irq, 1'b0);
    endtask : t_fault

    task automatic t_status();
        wr(`MFR_OFF_FLT_EN, 32'h00000000);
        flt <= 6'h3F;
        spd <= 1'b1;
        pwr <= 1'b1;
        cyc(4);
        rd(`MFR_OFF_STATUS, rv); chk(rv[10:0], 11'h1FF);
        chk(o_mode, 2'h0);
        rd(`MFR_OFF_MODE, rv); chk(rv[4:0], 5'h04);
    endtask : t_status

    // --------------------------------------------------------------
    // Main sequence and watchdog
    // --------------------------------------------------------------
    initial begin
        repeat (20) @(posedge i_mclk);
        i_rst <= 1'b0;
        cyc(1);
        t_reset();
        t_start();
        t_gains();
        t_regen();
        t_brake();
        t_fault();
        t_status();
        finish_test();
    end

    initial begin
        #200000;
        n_fail++;
        finish_test();
    end
endmodule : motor_mode_fsm_regen_limit_tb
